// >>> logic/charger_status_consts.vh
// Offsets, field positions, codes and timing for the charger status port
`ifndef CHARGER_STATUS_CONSTS_VH
`define CHARGER_STATUS_CONSTS_VH
`define CMD_CHARGER_STATE 16'h00b8
`define CMD_SYSTEM_SETUP 16'h00be
`define CMD_SYSTEM_STATE 16'h00bf
`define CMD_CAN_SYSTEM_SETUP 16'h00c2
`define CMD_CAN_SYSTEM_STATE 16'h00c1
`define SETUP_WRITE_MASK 16'h0707
`define SETUP_RESET 16'h0002
`define INIT_OFF 2'b00
`define INIT_ON 2'b01
`define INIT_LAST 2'b10
`define NV_IMMEDIATE 2'b00
`define NV_ONE_MIN 2'b01
`define NV_TEN_MIN 2'b10
`define CAN_ID_REPLY 29'h000c0000
`define CAN_ID_REQUEST 29'h000c0100
`define CAN_ID_BROADCAST 29'h000c01ff
`define CLK_HZ 34'd20000000
`define REPLY_MAX_US 12500
`define ONE_MIN_S 34'd60
`define TEN_MIN_S 34'd600
`define LEN_READ 4'h2
`define LEN_WRITE 4'h4
`define LEN_REPLY 4'h4
`define SETUP_CTRL_BIT 0
`define SETUP_INIT_HI 2
`define SETUP_INIT_LO 1
`define SETUP_NV_HI 9
`define SETUP_NV_LO 8
`define SETUP_NV_OFF_BIT 10
`define VOUT_MODE_CODE 8'h17
`define VOUT_EXP -9
`endif

// >>> logic/charger_status_port.v
// Charger status, system setup and system state command port
`timescale 1ns/1ps
`default_nettype none
`include "charger_status_consts.vh"
//
// Contract
// [RULE1] Low byte shows full, CC, CV, float
// [RULE2] Temp-comp short flags, shuts output, auto restart
// [RULE3] No battery latches until fresh power-up
// [RULE4] High bits 5-7 flag stage timeouts
// [RULE5] CC/CV timeout stops charging, red, restart
// [RULE6] Float timeout stops charging, green, done
// [RULE7] Setup bit 0 selects bus control
// [RULE8] Setup bits 1-2 select power-up state
// [RULE9] Setup high bits 0-1 pick save delay
// [RULE10] Setup high bit 2 suppresses saving
// [RULE11] State bit 1 shows output in range
// [RULE12] State bit 4 dummy load, bit 5 initial
// [RULE13] State bit 6 flags memory error, halts
// [RULE14] Unsupported bits always read zero
// [RULE15] Host spaces two-wire commands 50 ms apart
// [RULE16] Short linear: 11-bit mantissa, 5-bit exponent
// [RULE17] Voltage mode 0x17 means exponent minus nine
// [RULE18] CAN 250 kbit/s, 29-bit extended frames
// [RULE19] Requests 50 ms apart, reply within 12.5 ms
// [RULE20] Write frame: command then data, low first
// [RULE21] Reads echo command plus data; writes silent
// [RULE22] Reply id 0c00XX, request 0c01XX, broadcast
// [RULE23] Charger flags only with curve enabled
// [RULE24] Timeout flags only when report enabled
// [RULE25] Flags sampled synchronously for coherent reads
module charger_status_port #(
  parameter [33:0] ONE_MIN_CYCLES = `CLK_HZ * `ONE_MIN_S, // 1 min delay
  parameter [33:0] TEN_MIN_CYCLES = `CLK_HZ * `TEN_MIN_S // 10 min delay
) (
  input wire sys_clk, // System clock, 20 MHz
  input wire sys_rst, // Synchronous reset, high
  input wire [1:0] unit_address, // Rotary switch address
  input wire cmd_valid, // Command strobe, one cycle
  input wire cmd_is_can, // Command came in a CAN frame
  input wire [28:0] cmd_can_id, // CAN identifier of the request
  input wire [3:0] cmd_len, // Data field length
  input wire [63:0] cmd_bytes, // Data field, byte 0 in bits 7:0
  input wire charge_curve_enable, // Charger mode enabled
  input wire cc_timeout_report_en, // CC timeout report enable
  input wire cv_timeout_report_en, // CV timeout report enable
  input wire float_timeout_report_en, // Float timeout report enable
  input wire stage_full, // Charger reports fully charged
  input wire stage_cc, // Charger in constant current
  input wire stage_cv, // Charger in constant voltage
  input wire stage_float, // Charger in float
  input wire temp_comp_short, // Temperature compensation shorted
  input wire battery_absent, // No battery detected
  input wire cc_timer_expired, // CC stage timer ran out
  input wire cv_timer_expired, // CV stage timer ran out
  input wire float_timer_expired, // Float stage timer ran out
  input wire remote_off, // Remote off request active
  input wire output_ok, // Output voltage in range
  input wire dummy_load_on, // Active dummy load engaged
  input wire initial_phase, // Unit in initial state
  input wire nv_error, // Nonvolatile access error
  input wire nv_busy, // Nonvolatile store in progress
  output reg [15:0] charger_state_flags, // Charger state word
  output reg [15:0] system_setup, // System setup word
  output reg [15:0] system_state_flags, // System state word
  output reg bus_control_select, // Bus owns V, I and on/off
  output reg charge_allowed, // Charger may charge
  output reg output_enable, // Power stage on
  output reg led_red, // Indicator red
  output reg led_green, // Indicator green
  output reg nv_store_req, // Save setup now, one cycle
  output reg reply_valid, // Reply frame ready, one cycle
  output reg [28:0] reply_id, // Reply identifier
  output reg [3:0] reply_len, // Reply data length
  output reg [63:0] reply_bytes // Reply data, byte 0 low
);
  localparam REPLY_CYCLES = `CLK_HZ / 1000000 * `REPLY_MAX_US;
  reg [15:0] next_setup;
  reg [15:0] cmd_code;
  reg [15:0] read_word;
  reg addressed;
  reg known;
  reg no_battery_latch;
  reg cc_to_latch;
  reg cv_to_latch;
  reg float_to_latch;
  reg nv_err_latch;
  reg remote_off_d;
  reg nv_pending;
  // Ten minutes of cycles needs 34 bits
  reg [33:0] nv_count;
  reg [33:0] nv_limit;
  reg [15:0] stored_setup;
  reg powered_up;
  reg last_on;
  wire write_req;
  wire remote_cycle;
  wire halted;

  // Command code always sits in bytes 0 and 1, low first
  always @* begin
    cmd_code = {cmd_bytes[15:8], cmd_bytes[7:0]}; // see [RULE20]
    addressed = !cmd_is_can ||
      cmd_can_id == (`CAN_ID_REQUEST | {27'h0, unit_address}) ||
      cmd_can_id == `CAN_ID_BROADCAST; // see [RULE22] [RULE18]
    known = 1'b1;
    read_word = 16'h0000;
    case (cmd_code)
      `CMD_CHARGER_STATE: read_word = charger_state_flags;
      `CMD_SYSTEM_SETUP: read_word = system_setup;
      `CMD_CAN_SYSTEM_SETUP: read_word = system_setup;
      `CMD_SYSTEM_STATE: read_word = system_state_flags;
      `CMD_CAN_SYSTEM_STATE: read_word = system_state_flags;
      default: known = 1'b0;
    endcase
  end

  assign write_req = cmd_valid && addressed && cmd_len == `LEN_WRITE &&
    (cmd_code == `CMD_SYSTEM_SETUP || cmd_code == `CMD_CAN_SYSTEM_SETUP);
  // Remote off/on counts as a restart when off is released
  assign remote_cycle = remote_off_d && !remote_off;
  assign halted = nv_err_latch;

  always @* begin
    next_setup = system_setup;
    if (write_req) begin
      // Unsupported bits are masked, reserved code 11 kept
      next_setup = {cmd_bytes[31:24], cmd_bytes[23:16]} &
        `SETUP_WRITE_MASK; // see [RULE14]
    end
  end

  always @* begin
    case (system_setup[`SETUP_NV_HI:`SETUP_NV_LO])
      `NV_ONE_MIN: nv_limit = ONE_MIN_CYCLES; // see [RULE9]
      `NV_TEN_MIN: nv_limit = TEN_MIN_CYCLES;
      default: nv_limit = 34'h0;
    endcase
  end

  // Setup word and the control source it selects
  always @(posedge sys_clk) begin
    if (sys_rst) begin
      system_setup <= `SETUP_RESET;
      bus_control_select <= 1'b0;
    end else begin
      system_setup <= next_setup;
      bus_control_select <= next_setup[`SETUP_CTRL_BIT]; // see [RULE7]
    end
  end

  // Fault latches; no battery and memory errors clear only by reset,
  // which stands for a fresh power-up
  always @(posedge sys_clk) begin
    if (sys_rst) begin
      no_battery_latch <= 1'b0;
      cc_to_latch <= 1'b0;
      cv_to_latch <= 1'b0;
      float_to_latch <= 1'b0;
      nv_err_latch <= 1'b0;
      remote_off_d <= 1'b0;
    end else begin
      remote_off_d <= remote_off;
      if (charge_curve_enable && battery_absent) begin
        no_battery_latch <= 1'b1; // see [RULE3]
      end
      // A new timeout beats a remote restart in the same cycle
      if (charge_curve_enable && cc_timeout_report_en &&
          cc_timer_expired) begin
        cc_to_latch <= 1'b1; // see [RULE24]
      end else if (remote_cycle) begin
        cc_to_latch <= 1'b0; // see [RULE5]
      end
      if (charge_curve_enable && cv_timeout_report_en &&
          cv_timer_expired) begin
        cv_to_latch <= 1'b1;
      end else if (remote_cycle) begin
        cv_to_latch <= 1'b0;
      end
      if (charge_curve_enable && float_timeout_report_en &&
          float_timer_expired) begin
        float_to_latch <= 1'b1;
      end else if (remote_cycle) begin
        float_to_latch <= 1'b0; // see [RULE6]
      end
      if (nv_error) begin
        nv_err_latch <= 1'b1; // see [RULE13]
      end
    end
  end

  // One synchronous snapshot per cycle keeps reads coherent
  always @(posedge sys_clk) begin
    if (sys_rst) begin
      charger_state_flags <= 16'h0000;
      system_state_flags <= 16'h0000;
    end else begin // see [RULE25]
      // Plain supply mode shows an all-zero charger word
      if (charge_curve_enable) begin
        charger_state_flags <= {float_to_latch, cv_to_latch,
          cc_to_latch, 1'b0, // see [RULE4]
          no_battery_latch, temp_comp_short, 2'b00, // see [RULE2]
          4'h0, stage_float, stage_cv, stage_cc, stage_full}; // see [RULE1]
      end else begin
        charger_state_flags <= 16'h0000; // see [RULE23]
      end
      system_state_flags <= {9'h0, nv_err_latch, initial_phase,
        dummy_load_on, 2'b00, output_ok, 1'b0}; // see [RULE11] [RULE12]
    end
  end

  // Output stage, charge permission and indicator
  always @(posedge sys_clk) begin
    if (sys_rst) begin
      charge_allowed <= 1'b0;
      output_enable <= 1'b0;
      led_red <= 1'b0;
      led_green <= 1'b0;
      powered_up <= 1'b0;
      // Last state is not kept across reset, so it restarts as on
      last_on <= 1'b1;
    end else begin
      powered_up <= 1'b1;
      charge_allowed <= charge_curve_enable && !halted &&
        !temp_comp_short && !no_battery_latch && !cc_to_latch &&
        !cv_to_latch && !float_to_latch; // see [RULE5]
      // First edge after power-up follows the stored start mode
      if (!powered_up) begin
        case (system_setup[`SETUP_INIT_HI:`SETUP_INIT_LO]) // see [RULE8]
          `INIT_OFF: output_enable <= 1'b0;
          `INIT_LAST: output_enable <= last_on;
          default: output_enable <= 1'b1;
        endcase
      end else begin
        output_enable <= !remote_off && !halted &&
          !(charge_curve_enable && temp_comp_short); // see [RULE2]
        last_on <= !remote_off;
      end
      // A float timeout ends the charge as done, so it stays green
      led_red <= halted || (charge_curve_enable && (temp_comp_short ||
        no_battery_latch || cc_to_latch || cv_to_latch));
      led_green <= !halted && !(charge_curve_enable && (temp_comp_short ||
        no_battery_latch || cc_to_latch || cv_to_latch)); // see [RULE6]
    end
  end

  // Save only after the setup has stood still for the delay
  always @(posedge sys_clk) begin
    if (sys_rst) begin
      nv_pending <= 1'b0;
      nv_count <= 34'h0;
      nv_store_req <= 1'b0;
      stored_setup <= `SETUP_RESET;
    end else begin
      nv_store_req <= 1'b0;
      if (next_setup != stored_setup &&
          !system_setup[`SETUP_NV_OFF_BIT]) begin // see [RULE10]
        if (next_setup != system_setup) begin
          // Any change restarts the quiet-time count
          nv_pending <= 1'b1;
          nv_count <= 34'h0;
        end else if (!nv_busy && nv_count >= nv_limit) begin
          nv_store_req <= 1'b1; // see [RULE9]
          stored_setup <= system_setup;
          nv_pending <= 1'b0;
        end else begin
          nv_count <= nv_count + 34'h1;
        end
      end else begin
        nv_pending <= 1'b0;
      end
    end
  end

  // Answer reads next cycle, far inside REPLY_CYCLES
  always @(posedge sys_clk) begin
    if (sys_rst) begin
      reply_valid <= 1'b0;
      reply_id <= 29'h0;
      reply_len <= 4'h0;
      reply_bytes <= 64'h0;
    end else begin // see [RULE19]
      // Broadcast reads stay silent so several units cannot collide
      reply_valid <= cmd_valid && addressed && known &&
        cmd_len == `LEN_READ &&
        !(cmd_is_can && cmd_can_id == `CAN_ID_BROADCAST); // see [RULE21]
      if (cmd_valid && cmd_len == `LEN_READ) begin
        reply_id <= `CAN_ID_REPLY | {27'h0, unit_address}; // see [RULE22]
        reply_len <= `LEN_REPLY;
        reply_bytes <= {32'h0, read_word, cmd_code};
      end
    end
  end
endmodule // charger_status_port
`default_nettype wire

// >>> testbench/charger_status_port_properties.sv
// Port properties of the charger status command port
`timescale 1ns/1ps
`default_nettype none
module charger_status_props (
  input wire logic sys_clk, // Clock
  input wire logic sys_rst, // Reset
  input wire logic [1:0] unit_address, // Address
  input wire logic cmd_valid, // Request
  input wire logic cmd_is_can, // CAN request
  input wire logic [28:0] cmd_can_id, // Request id
  input wire logic [3:0] cmd_len, // Length
  input wire logic [63:0] cmd_bytes, // Data
  input wire logic charge_curve_enable, // Charger mode
  input wire logic stage_cc, // CC stage
  input wire logic battery_absent, // No battery
  input wire logic output_ok, // Output good
  input wire logic nv_error, // Memory error
  input wire logic [15:0] charger_state_flags, // Charger word
  input wire logic [15:0] system_setup, // Setup word
  input wire logic [15:0] system_state_flags, // State word
  input wire logic bus_control_select, // Bus control
  input wire logic reply_valid, // Reply strobe
  input wire logic [28:0] reply_id, // Reply id
  input wire logic [63:0] reply_bytes // Reply data
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (sys_rst);
  a_read_echo: assert property (cmd_valid && !cmd_is_can &&
    cmd_len == 4'h2 && cmd_bytes[15:0] == 16'h00b8 |=>
    reply_valid && reply_bytes[15:0] == 16'h00b8) else $error("no echo");
  a_write_quiet: assert property (cmd_valid && cmd_len == 4'h4
    |=> !reply_valid) else $error("write answered");
  a_reply_id: assert property (reply_valid |->
    reply_id == {21'h000c00, 6'h00, unit_address}) else $error("bad id");
  a_bcast_quiet: assert property (cmd_valid && cmd_is_can &&
    cmd_can_id == 29'h000c01ff |=> !reply_valid) else $error("bcast reply");
  a_unused_zero: assert property ((charger_state_flags & 16'h13f0) == 0 &&
    (system_setup & 16'hf8f8) == 0 && (system_state_flags & 16'hff8d) == 0)
    else $error("unused bit set");
  a_curve_gate: assert property (!charge_curve_enable |=>
    charger_state_flags[3:0] == 4'h0) else $error("flags while off");
  a_cc_mirror: assert property (charge_curve_enable |=>
    charger_state_flags[1] == $past(stage_cc)) else $error("cc flag");
  a_range_mirror: assert property (##1
    system_state_flags[1] == $past(output_ok)) else $error("range flag");
  a_nv_halt: assert property (nv_error || system_state_flags[6]
    |-> ##2 system_state_flags[6]) else $error("nv flag lost");
  a_batt_latch: assert property (charge_curve_enable &&
    (battery_absent || charger_state_flags[11]) ##1 charge_curve_enable
    |=> charger_state_flags[11]) else $error("battery flag lost");
  a_ctrl_select: assert property (bus_control_select ==
    system_setup[0]) else $error("control select");
  c_reply: cover property (reply_valid);
  c_write: cover property (cmd_valid && cmd_len == 4'h4);
  c_batt: cover property (charger_state_flags[11]);
endmodule // charger_status_props
bind charger_status_port charger_status_props chk_u (.*);
`default_nettype wire

// >>> testbench/ctrl_model.sv
// Controller model issuing command frames to the port
`timescale 1ns/1ps
`default_nettype none
module ctrl_model (
  input wire logic sys_clk, // System clock
  output logic cmd_valid, // Request strobe
  output logic cmd_is_can, // CAN request
  output logic [28:0] cmd_can_id, // Request id
  output logic [3:0] cmd_len, // Data length
  output logic [63:0] cmd_bytes // Data field
);
  initial begin
    {cmd_valid, cmd_is_can, cmd_can_id, cmd_len} = '0;
    cmd_bytes = 64'h5a5a_a5a5_5a5a_a5a5;
  end
  task automatic req(input logic can, input logic [28:0] id,
    input logic [15:0] cmd, input logic wr, input logic [15:0] dat);
    // Gaps are cycles, not 50 ms: the port takes any spacing
    @(posedge sys_clk);
    #1;
    cmd_is_can = can;
    cmd_can_id = id;
    cmd_len = wr ? 4'h4 : 4'h2;
    cmd_bytes = wr ? {32'h0, dat, cmd} : {48'h0, cmd};
    cmd_valid = 1'b1;
    @(posedge sys_clk);
    #1;
    cmd_valid = 1'b0;
    // Released field scrambled so stale data cannot pass
    cmd_bytes = ~cmd_bytes;
  endtask
endmodule // ctrl_model
`default_nettype wire

// >>> testbench/tb_charger_status_port.sv
// Self-checking bench for the charger status command port
`timescale 1ns/1ps
`default_nettype none
module tb_charger_status_port;
  localparam logic [18:0] CE = 19'h00010;
  logic sys_clk = 1'b0;
  logic sys_rst = 1'b1;
  logic [1:0] unit_address = 2'h2;
  logic [18:0] st = 19'h0;
  logic cmd_valid, cmd_is_can, reply_valid, nv_store_req;
  logic [28:0] cmd_can_id, reply_id;
  logic [3:0] cmd_len;
  logic [63:0] cmd_bytes, reply_bytes;
  logic [15:0] charger_state_flags, system_setup, system_state_flags;
  logic bus_control_select, charge_allowed, output_enable, led_red, led_green;
  wire stage_full, stage_cc, stage_cv, stage_float, charge_curve_enable;
  wire cc_timeout_report_en, cv_timeout_report_en, float_timeout_report_en;
  wire temp_comp_short, battery_absent, cc_timer_expired, cv_timer_expired;
  wire float_timer_expired, remote_off, output_ok, dummy_load_on;
  wire initial_phase, nv_error, nv_busy;
  int n_fail = 0, compares = 0, nv_cnt = 0, i, c;
  assign {nv_busy, nv_error, initial_phase, dummy_load_on, output_ok,
    remote_off, float_timer_expired, cv_timer_expired, cc_timer_expired,
    battery_absent, temp_comp_short, float_timeout_report_en,
    cv_timeout_report_en, cc_timeout_report_en, charge_curve_enable,
    stage_float, stage_cv, stage_cc, stage_full} = st;
  charger_status_port #(.ONE_MIN_CYCLES(20), .TEN_MIN_CYCLES(50)) dut_u (
    .reply_len(), .*);
  ctrl_model p (.*);
  always #25 sys_clk = ~sys_clk;
  always @(posedge sys_clk) if (nv_store_req === 1'b1) nv_cnt <= nv_cnt + 1;
  task automatic chk(input logic [32:0] got, input logic [32:0] exp);
    compares++;
    if (got !== exp) begin
      n_fail++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic set(input logic [18:0] v);
    @(posedge sys_clk);
    #1 st = v;
    // One more edge so latched flags are set; status words take them on the next edge
    @(posedge sys_clk);
  endtask
  task automatic rd(input logic [15:0] cmd, input logic [15:0] exp);
    p.req(1'b0, 29'h0, cmd, 1'b0, 16'h0);
    chk({reply_valid, reply_bytes[31:0]}, {1'b1, exp, cmd});
  endtask
  task automatic wr(input logic [15:0] cmd, input logic [15:0] dat);
    p.req(1'b0, 29'h0, cmd, 1'b1, dat);
    chk(reply_valid, 0);
  endtask
  task automatic crd(input logic [28:0] id, input logic exp);
    p.req(1'b1, id, 16'h00c1, 1'b0, 16'h0);
    chk(reply_valid, exp);
    if (exp) chk(reply_id, {21'h000c00, 6'h00, unit_address});
  endtask
  // Bounded wait for a store pulse, delay must fall in lo..hi
  task automatic nvw(input int lo, input int hi);
    int n = 0;
    int c0 = nv_cnt;
    while (nv_cnt == c0 && n <= hi) begin
      @(posedge sys_clk);
      #1 n++;
    end
    chk(n >= lo && n <= hi, 1);
  endtask
  task automatic print_verdict;
    $display("Checks: %0d, failures: %0d", compares, n_fail);
    if (n_fail == 0 && compares > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  initial begin
    repeat (4) @(posedge sys_clk);
    #1 sys_rst = 1'b0;
    rd(16'h00be, 16'h0002);
    set(CE | 19'h1c000);
    rd(16'h00bf, 16'h0032);
    wr(16'h00be, 16'hffff);
    rd(16'h00be, 16'h0707);
    chk(bus_control_select, 1);
    wr(16'h00be, 16'h0003);
    nvw(0, 5);
    wr(16'h00be, 16'h0102);
    nvw(18, 26);
    wr(16'h00be, 16'h0402);
    c = nv_cnt;
    repeat (60) @(posedge sys_clk);
    chk(nv_cnt - c, 0);
    wr(16'h00be, 16'h0002);
    for (i = 0; i < 4; i++) begin
      set(CE | (19'h1 << i));
      rd(16'h00b8, 16'h1 << i);
    end
    set(19'h0000f);
    rd(16'h00b8, 16'h0000);
    set(CE | 19'h00100);
    rd(16'h00b8, 16'h0400);
    chk({output_enable, led_red}, 2'b01);
    set(CE);
    rd(16'h00b8, 16'h0000);
    chk(output_enable, 1);
    for (i = 0; i < 3; i++) begin
      set(CE | (19'h00420 << i));
      rd(16'h00b8, 16'h2000 << i);
      chk({charge_allowed, led_red, led_green}, (i == 2) ? 3'b001 : 3'b010);
      set(CE | 19'h02000);
      set(CE);
      rd(16'h00b8, 16'h0000);
    end
    set(CE | 19'h00400);
    rd(16'h00b8, 16'h0000);
    set(CE | 19'h00200);
    set(CE);
    rd(16'h00b8, 16'h0800);
    chk(charge_allowed, 0);
    crd(29'h000c0102, 1'b1);
    crd(29'h000c0101, 1'b0);
    crd(29'h000c01ff, 1'b0);
    set(CE | 19'h24000);
    rd(16'h00bf, 16'h0042);
    chk(led_red, 1);
    set(CE);
    #1 sys_rst = 1'b1;
    repeat (2) @(posedge sys_clk);
    #1 sys_rst = 1'b0;
    rd(16'h00b8, 16'h0000);
    print_verdict;
  end
endmodule // tb_charger_status_port
`default_nettype wire
